// file: src/vat_pkg.sv
// constants and field layouts for the virtual address translation unit
package vat_pkg;

  // address split
  localparam int unsigned VAT_ADDR_W    = 32;
  localparam int unsigned VAT_VPN_W     = 20;
  localparam int unsigned VAT_OFF_W     = 12;
  localparam int unsigned VAT_PFN_W     = 20;
  localparam int unsigned VAT_BYP_W     = 29;
  localparam int unsigned VAT_PID_W_DEF = 8;
  localparam int unsigned VAT_PID_W_MAX = 14;

  // translation buffer size
  localparam int unsigned VAT_ENTRIES = 16;
  localparam int unsigned VAT_IDX_W   = 4;

  // reset tags sit in the peripheral partition, which bypasses the buffer, so no reset entry ever translates an address
  localparam logic [VAT_VPN_W-1:0] VAT_TAG_RST_BASE = 20'he0000;

  // partition selectors on the top address bits
  localparam logic [2:0] VAT_PART_IO   = 3'h7;
  localparam logic [2:0] VAT_PART_KERN = 3'h6;
  localparam logic [1:0] VAT_PART_KMMU = 2'h2;
  localparam logic       VAT_PART_USER = 1'h0;

  // access kinds
  localparam logic [1:0] VAT_KIND_FETCH = 2'h0;
  localparam logic [1:0] VAT_KIND_LOAD  = 2'h1;
  localparam logic [1:0] VAT_KIND_STORE = 2'h2;
  localparam logic [1:0] VAT_KIND_FLUSH = 2'h3;

  // exception causes
  localparam logic [2:0] VAT_CAUSE_NONE   = 3'h0;
  localparam logic [2:0] VAT_CAUSE_FAST   = 3'h1;
  localparam logic [2:0] VAT_CAUSE_DOUBLE = 3'h2;
  localparam logic [2:0] VAT_CAUSE_PERM   = 3'h3;
  localparam logic [2:0] VAT_CAUSE_SUPER  = 3'h4;

  // register byte offsets
  localparam logic [7:0] VAT_OFS_CTRL  = 8'h00;
  localparam logic [7:0] VAT_OFS_IDX   = 8'h04;
  localparam logic [7:0] VAT_OFS_TAG   = 8'h08;
  localparam logic [7:0] VAT_OFS_TPID  = 8'h0c;
  localparam logic [7:0] VAT_OFS_DATA  = 8'h10;
  localparam logic [7:0] VAT_OFS_FADDR = 8'h14;
  localparam logic [7:0] VAT_OFS_FCAUS = 8'h18;

  // field positions
  localparam int unsigned VAT_BIT_EH     = 16;
  localparam int unsigned VAT_BIT_G      = 20;
  localparam int unsigned VAT_BIT_C      = 20;
  localparam int unsigned VAT_BIT_R      = 21;
  localparam int unsigned VAT_BIT_W      = 22;
  localparam int unsigned VAT_BIT_X      = 23;
  localparam int unsigned VAT_BIT_PEND   = 8;

  // values after reset
  localparam logic [31:0] VAT_RST_WORD = 32'h0000_0000;
  localparam logic        VAT_RST_BIT  = 1'h0;

endpackage

// file: src/vat_part_dec.sv
// fixed partition decoder for the top virtual address bits
`timescale 1ns/1ps
`default_nettype none
module vat_part_dec
  import vat_pkg::*;
(
  // address
  input  wire logic [2:0] top_bits,
  // partition properties
  output logic            bypass,
  output logic            super_only,
  output logic            byp_cacheable
);

  // bit 31 alone never selects cacheability
  always_comb begin
    bypass        = 1'b0;
    super_only    = 1'b0;
    byp_cacheable = 1'b0;
    if (top_bits == VAT_PART_IO) begin
      bypass     = 1'b1;
      super_only = 1'b1;
    end else if (top_bits == VAT_PART_KERN) begin
      bypass        = 1'b1;
      super_only    = 1'b1;
      byp_cacheable = 1'b1;
    end else if (top_bits[2:1] == VAT_PART_KMMU) begin
      super_only = 1'b1;
    end else if (top_bits[2] == VAT_PART_USER) begin
      super_only = 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: src/vat_tlb.sv
// software-loaded translation buffer with fully associative lookup
`timescale 1ns/1ps
`default_nettype none
module vat_tlb
  import vat_pkg::*;
#(
  parameter int unsigned PID_W = VAT_PID_W_DEF
)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // load port
  input  wire logic                 wr_en,
  input  wire logic [VAT_IDX_W-1:0] wr_idx,
  input  wire logic [VAT_VPN_W-1:0] wr_vpn,
  input  wire logic [PID_W-1:0]     wr_pid,
  input  wire logic                 wr_g,
  input  wire logic [VAT_PFN_W-1:0] wr_pfn,
  input  wire logic [3:0]           wr_perm,
  // lookup port
  input  wire logic [VAT_VPN_W-1:0] virtual_page_number,
  input  wire logic [PID_W-1:0]     process_identifier,
  output logic                      hit,
  output logic [VAT_PFN_W-1:0]      physical_frame_number,
  output logic [3:0]                perm
);

  // perm holds {x, w, r, c}
  logic [VAT_VPN_W-1:0] tag_vpn [VAT_ENTRIES];
  logic [PID_W-1:0]     tag_pid [VAT_ENTRIES];
  logic                 tag_g   [VAT_ENTRIES];
  logic [VAT_PFN_W-1:0] dat_pfn [VAT_ENTRIES];
  logic [3:0]           dat_prm [VAT_ENTRIES];

  // only software writes entries; nothing here walks a page table
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < VAT_ENTRIES; i++) begin
        tag_vpn[i] <= VAT_TAG_RST_BASE + VAT_VPN_W'(i);
        tag_pid[i] <= '0;
        tag_g[i]   <= 1'b0;
        dat_pfn[i] <= '0;
        dat_prm[i] <= '0;
      end
    end else if (wr_en) begin
      tag_vpn[wr_idx] <= wr_vpn;
      tag_pid[wr_idx] <= wr_pid;
      tag_g[wr_idx]   <= wr_g;
      dat_pfn[wr_idx] <= wr_pfn;
      dat_prm[wr_idx] <= wr_perm;
    end
  end

  // duplicate mappings are software's fault; results are or-ed together
  always_comb begin
    hit                   = 1'b0;
    physical_frame_number = '0;
    perm                  = '0;
    for (int i = 0; i < VAT_ENTRIES; i++) begin
      if (tag_vpn[i] == virtual_page_number && (tag_g[i] || tag_pid[i] == process_identifier)) begin
        hit                   = 1'b1;
        physical_frame_number = physical_frame_number | dat_pfn[i];
        perm                  = perm | dat_prm[i];
      end
    end
  end

endmodule
`default_nettype wire

// file: src/vat_top.sv
// virtual address translation unit: apb registers, partition checks and translation
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module vat_top
  import vat_pkg::*;
#(
  parameter int unsigned PID_W = VAT_PID_W_DEF  // keep within 8..14
)
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // translation request from the pipeline
  input  wire logic                  req_valid,
  input  wire logic [VAT_ADDR_W-1:0] req_vaddr,
  input  wire logic [1:0]            req_kind,
  input  wire logic                  req_io,
  input  wire logic                  req_user,
  // translation result
  output logic                       rsp_valid,
  output logic [VAT_ADDR_W-1:0]      rsp_paddr,
  output logic                       rsp_cacheable,
  output logic                       rsp_fault,
  output logic [2:0]                 rsp_cause
);

  function automatic logic ofs_mapped(input logic [31:0] a);
    ofs_mapped = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'h0) && (a[7:0] <= VAT_OFS_FCAUS);
  endfunction

  // register state
  logic [PID_W-1:0]     process_identifier;
  logic                 exception_handler_flag;
  logic [VAT_IDX_W-1:0] entry_idx;
  logic [VAT_VPN_W-1:0] stage_vpn;
  logic                 stage_g;
  logic [PID_W-1:0]     stage_pid;
  logic [VAT_PFN_W-1:0] stage_pfn;
  logic [3:0]           stage_perm;
  logic [31:0]          fault_addr;
  logic [2:0]           fault_cause;
  logic                 fault_pend;
  logic [PID_W-1:0]     next_process_identifier;
  logic                 next_exception_handler_flag;
  logic [VAT_IDX_W-1:0] next_entry_idx;
  logic [VAT_VPN_W-1:0] next_stage_vpn;
  logic                 next_stage_g;
  logic [PID_W-1:0]     next_stage_pid;
  logic [VAT_PFN_W-1:0] next_stage_pfn;
  logic [3:0]           next_stage_perm;
  logic [31:0]          next_fault_addr;
  logic [2:0]           next_fault_cause;
  logic                 next_fault_pend;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;

  // translation state
  logic                  next_rsp_valid;
  logic [VAT_ADDR_W-1:0] next_rsp_paddr;
  logic                  next_rsp_cacheable;
  logic                  next_rsp_fault;
  logic [2:0]            next_rsp_cause;

  // lookup wires
  logic                 bypass;
  logic                 super_only;
  logic                 byp_cacheable;
  logic                 tlb_hit;
  logic [VAT_PFN_W-1:0] tlb_pfn;
  logic [3:0]           tlb_perm;
  logic                 tlb_load;
  logic                 apb_wr;
  logic                 apb_setup;
  logic                 perm_ok;
  logic                 is_data;
  logic                 raw_fault;

  vat_part_dec u_part (
    .top_bits      (req_vaddr[31:29]),
    .bypass        (bypass),
    .super_only    (super_only),
    .byp_cacheable (byp_cacheable)
  );

  vat_tlb #(
    .PID_W (PID_W)
  ) u_tlb (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .wr_en                 (tlb_load),
    .wr_idx                (entry_idx),
    .wr_vpn                (stage_vpn),
    .wr_pid                (stage_pid),
    .wr_g                  (stage_g),
    .wr_pfn                (next_stage_pfn),
    .wr_perm               (next_stage_perm),
    .virtual_page_number   (req_vaddr[VAT_ADDR_W-1:VAT_OFF_W]),
    .process_identifier    (process_identifier),
    .hit                   (tlb_hit),
    .physical_frame_number (tlb_pfn),
    .perm                  (tlb_perm)
  );

  // translation decision; the result registers one cycle after the request
  always_comb begin
    is_data = (req_kind != VAT_KIND_FETCH);
    unique case (req_kind)
      VAT_KIND_FETCH: perm_ok = tlb_perm[3];
      VAT_KIND_LOAD:  perm_ok = tlb_perm[1];
      VAT_KIND_STORE: perm_ok = tlb_perm[2];
      VAT_KIND_FLUSH: perm_ok = 1'b1;
    endcase
    next_rsp_valid = req_valid;
    next_rsp_cause = VAT_CAUSE_NONE;
    if (req_user && super_only) begin
      next_rsp_cause = VAT_CAUSE_SUPER;
    end else if (!bypass && !tlb_hit) begin
      next_rsp_cause = exception_handler_flag ? VAT_CAUSE_DOUBLE : VAT_CAUSE_FAST;
    end else if (!bypass && !perm_ok) begin
      next_rsp_cause = VAT_CAUSE_PERM;
    end
    raw_fault      = req_valid && (next_rsp_cause != VAT_CAUSE_NONE);
    next_rsp_fault = raw_fault;
    // high frames only ever come out of the buffer path
    if (bypass) begin
      next_rsp_paddr = {3'h0, req_vaddr[VAT_BYP_W-1:0]};
    end else begin
      next_rsp_paddr = {tlb_pfn, req_vaddr[VAT_OFF_W-1:0]};
    end
    // fetches report uncached: cacheability here speaks of data only
    next_rsp_cacheable = is_data && !req_io && (bypass ? byp_cacheable : tlb_perm[0]);
    if (raw_fault) begin
      next_rsp_paddr     = '0;
      next_rsp_cacheable = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid     <= VAT_RST_BIT;
      rsp_paddr     <= VAT_RST_WORD;
      rsp_cacheable <= VAT_RST_BIT;
      rsp_fault     <= VAT_RST_BIT;
      rsp_cause     <= VAT_CAUSE_NONE;
    end else begin
      rsp_valid     <= next_rsp_valid;
      rsp_paddr     <= next_rsp_paddr;
      rsp_cacheable <= next_rsp_cacheable;
      rsp_fault     <= next_rsp_fault;
      rsp_cause     <= next_rsp_cause;
    end
  end

  // register file; pready is a flop so every access completes with no wait state
  always_comb begin
    apb_setup                   = psel && !penable;
    apb_wr                      = psel && penable && pready && pwrite && !pslverr;
    next_process_identifier     = process_identifier;
    next_exception_handler_flag = exception_handler_flag;
    next_entry_idx              = entry_idx;
    next_stage_vpn              = stage_vpn;
    next_stage_g                = stage_g;
    next_stage_pid              = stage_pid;
    next_stage_pfn              = stage_pfn;
    next_stage_perm             = stage_perm;
    next_fault_addr             = fault_addr;
    next_fault_cause            = fault_cause;
    next_fault_pend             = fault_pend;
    tlb_load                    = 1'b0;
    if (apb_wr) begin
      unique case (paddr[7:0])
        VAT_OFS_CTRL: begin
          next_process_identifier     = pwdata[PID_W-1:0];
          next_exception_handler_flag = pwdata[VAT_BIT_EH];
        end
        VAT_OFS_IDX: next_entry_idx = pwdata[VAT_IDX_W-1:0];
        VAT_OFS_TAG: begin
          next_stage_vpn = pwdata[VAT_VPN_W-1:0];
          next_stage_g   = pwdata[VAT_BIT_G];
        end
        VAT_OFS_TPID: next_stage_pid = pwdata[PID_W-1:0];
        VAT_OFS_DATA: begin
          next_stage_pfn  = pwdata[VAT_PFN_W-1:0];
          next_stage_perm = {pwdata[VAT_BIT_X], pwdata[VAT_BIT_W], pwdata[VAT_BIT_R], pwdata[VAT_BIT_C]};
          tlb_load        = 1'b1;
        end
        VAT_OFS_FCAUS: begin
          if (pwdata[VAT_BIT_PEND]) begin
            next_fault_pend = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware sets after the software clear so a same-cycle fault is kept
    if (raw_fault) begin
      next_fault_addr             = req_vaddr;
      next_fault_cause            = next_rsp_cause;
      next_fault_pend             = 1'b1;
      next_exception_handler_flag = 1'b1;
    end
    next_pready  = apb_setup;
    next_pslverr = apb_setup && !ofs_mapped(paddr);
    next_prdata  = '0;
    if (apb_setup) begin
      unique case (paddr[7:0])
        VAT_OFS_CTRL: begin
          next_prdata[PID_W-1:0]   = process_identifier;
          next_prdata[VAT_BIT_EH]  = exception_handler_flag;
        end
        VAT_OFS_IDX:  next_prdata[VAT_IDX_W-1:0] = entry_idx;
        VAT_OFS_TAG: begin
          next_prdata[VAT_VPN_W-1:0] = stage_vpn;
          next_prdata[VAT_BIT_G]     = stage_g;
        end
        VAT_OFS_TPID: next_prdata[PID_W-1:0] = stage_pid;
        VAT_OFS_DATA: begin
          next_prdata[VAT_PFN_W-1:0]           = stage_pfn;
          next_prdata[VAT_BIT_X:VAT_BIT_C]     = {stage_perm[3], stage_perm[2], stage_perm[1], stage_perm[0]};
        end
        VAT_OFS_FADDR: next_prdata = fault_addr;
        VAT_OFS_FCAUS: begin
          next_prdata[2:0]          = fault_cause;
          next_prdata[VAT_BIT_PEND] = fault_pend;
        end
        default: next_prdata = '0;
      endcase
      if (!ofs_mapped(paddr)) begin
        next_prdata = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      process_identifier     <= '0;
      exception_handler_flag <= VAT_RST_BIT;
      entry_idx              <= '0;
      stage_vpn              <= '0;
      stage_g                <= VAT_RST_BIT;
      stage_pid              <= '0;
      stage_pfn              <= '0;
      stage_perm             <= '0;
      fault_addr             <= VAT_RST_WORD;
      fault_cause            <= VAT_CAUSE_NONE;
      fault_pend             <= VAT_RST_BIT;
      prdata                 <= VAT_RST_WORD;
      pready                 <= VAT_RST_BIT;
      pslverr                <= VAT_RST_BIT;
    end else begin
      process_identifier     <= next_process_identifier;
      exception_handler_flag <= next_exception_handler_flag;
      entry_idx              <= next_entry_idx;
      stage_vpn              <= next_stage_vpn;
      stage_g                <= next_stage_g;
      stage_pid              <= next_stage_pid;
      stage_pfn              <= next_stage_pfn;
      stage_perm             <= next_stage_perm;
      fault_addr             <= next_fault_addr;
      fault_cause            <= next_fault_cause;
      fault_pend             <= next_fault_pend;
      prdata                 <= next_prdata;
      pready                 <= next_pready;
      pslverr                <= next_pslverr;
    end
  end

endmodule
`default_nettype wire

// file: tb/vat_top_props.sv
// concurrent checks on the translation unit ports
`timescale 1ns/1ps
`default_nettype none
module vat_top_props
  import vat_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // translation
  input wire logic        req_valid,
  input wire logic [31:0] req_vaddr,
  input wire logic [1:0]  req_kind,
  input wire logic        req_io,
  input wire logic        req_user,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_paddr,
  input wire logic        rsp_cacheable,
  input wire logic        rsp_fault,
  input wire logic [2:0]  rsp_cause
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence req_bypass;
    req_valid && !req_user && req_vaddr[31:30] == 2'b11;
  endsequence
  sequence req_kern_data;
    req_valid && !req_user && !req_io && req_kind != VAT_KIND_FETCH && req_vaddr[31:29] == VAT_PART_KERN;
  endsequence
  apb_answer_a: assert property (apb_setup |=> pready ##1 !pready) else $error("apb answer timing");
  apb_refuse_a: assert property (apb_setup ##0 paddr > 32'h18 |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  rsp_answer_a: assert property (req_valid |=> rsp_valid) else $error("missing result");
  rsp_single_a: assert property (req_valid ##1 !req_valid |=> !rsp_valid) else $error("result too long");
  bypass_addr_a: assert property (req_bypass |=> !rsp_fault && rsp_paddr == {3'h0, $past(req_vaddr[28:0])})
    else $error("bypass address wrong");
  io_uncached_a: assert property (req_valid && req_vaddr[31:29] == VAT_PART_IO |=> !rsp_cacheable)
    else $error("peripheral partition cached");
  kern_cached_a: assert property (req_kern_data |=> rsp_cacheable) else $error("kernel data not cached");
  user_block_a: assert property (req_valid && req_user && req_vaddr[31]
    |=> rsp_fault && rsp_cause == VAT_CAUSE_SUPER) else $error("user reached supervisor partition");
  io_insn_a: assert property (req_valid && req_io |=> !rsp_cacheable) else $error("peripheral access cached");
  offset_keep_a: assert property (rsp_valid && !rsp_fault |-> rsp_paddr[11:0] == $past(req_vaddr[11:0]))
    else $error("page offset altered");
  fault_flag_a: assert property (rsp_valid |-> rsp_fault == (rsp_cause != VAT_CAUSE_NONE))
    else $error("fault flag and cause disagree");
endmodule
bind vat_top vat_top_props vat_top_props_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .req_valid(req_valid), .req_vaddr(req_vaddr), .req_kind(req_kind), .req_io(req_io), .req_user(req_user),
  .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr), .rsp_cacheable(rsp_cacheable), .rsp_fault(rsp_fault),
  .rsp_cause(rsp_cause));
`default_nettype wire

// file: tb/vat_pipe_model.sv
// pipeline model that issues translation requests and collects results
`timescale 1ns/1ps
`default_nettype none
module vat_pipe_model
(
  // clock
  input  wire logic        sys_clk,
  // request
  output logic             req_valid,
  output logic [31:0]      req_vaddr,
  output logic [1:0]       req_kind,
  output logic             req_io,
  output logic             req_user,
  // result
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_paddr,
  input  wire logic        rsp_cacheable,
  input  wire logic        rsp_fault,
  input  wire logic [2:0]  rsp_cause
);
  initial begin
    req_valid = 1'h0;
    req_vaddr = 32'h0;
    req_kind = 2'h0;
    req_io = 1'h0;
    req_user = 1'h0;
  end
  // a result later than a few cycles comes back with valid low and shows as a mismatch
  task automatic issue(input logic [31:0] va, input logic [1:0] k, input logic io, input logic us,
                       output logic [37:0] res);
    int n;
    req_valid <= 1'h1;
    req_vaddr <= va;
    req_kind <= k;
    req_io <= io;
    req_user <= us;
    @(posedge sys_clk);
    // released lines show inverted values so a stale sample cannot pass
    req_valid <= 1'h0;
    req_vaddr <= ~va;
    req_kind <= ~k;
    req_io <= ~io;
    req_user <= ~us;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 4);
    res = {rsp_valid, rsp_paddr, rsp_cacheable, rsp_fault, rsp_cause};
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the translation unit against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vat_pkg::*;
  localparam int unsigned PW = 10;
  logic          sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [31:0]   paddr, pwdata, prdata, req_vaddr, rsp_paddr;
  logic          req_valid, req_io, req_user, rsp_valid, rsp_cacheable, rsp_fault;
  logic [1:0]    req_kind;
  logic [2:0]    rsp_cause, fcause;
  int            num_errors, tests_run, cycles;
  logic [19:0]   m_vpn [16];
  logic [PW-1:0] m_pid [16];
  logic          m_g [16];
  logic [23:0]   m_dat [16];
  logic [PW-1:0] cur_pid;
  logic          eh, pend;
  logic [31:0]   faddr;
  vat_top #(.PID_W(PW)) vat_top_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_vaddr(req_vaddr), .req_kind(req_kind), .req_io(req_io), .req_user(req_user),
    .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr), .rsp_cacheable(rsp_cacheable), .rsp_fault(rsp_fault),
    .rsp_cause(rsp_cause));
  vat_pipe_model vat_pipe_model_inst (.sys_clk(sys_clk), .req_valid(req_valid), .req_vaddr(req_vaddr),
    .req_kind(req_kind), .req_io(req_io), .req_user(req_user), .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr),
    .rsp_cacheable(rsp_cacheable), .rsp_fault(rsp_fault), .rsp_cause(rsp_cause));
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ceiling well above the expected run of about 1300 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // released lines show inverted values so a stale decode cannot pass
    pwrite <= ~wr;
    paddr <= ~a;
    pwdata <= ~wd;
    if (pready !== 1'h1) chk(38'h1, 38'h0);
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge sys_clk);
  endtask
  task automatic check_regs();
    logic [31:0] rd;
    logic err;
    apb(1'h0, 32'(VAT_OFS_CTRL), 32'h0, rd, err);
    chk({err, rd}, 32'({eh, 16'h0}) | 32'(cur_pid));
    apb(1'h0, 32'(VAT_OFS_FADDR), 32'h0, rd, err);
    chk({err, rd}, faddr);
    apb(1'h0, 32'(VAT_OFS_FCAUS), 32'h0, rd, err);
    chk({err, rd}, 32'({pend, 8'h0}) | 32'(fcause));
  endtask
  function automatic logic [37:0] predict(input logic [31:0] va, input logic [1:0] k, input logic io,
                                          input logic us);
    logic [31:0] pa;
    logic        c;
    logic [2:0]  cs;
    int          h;
    pa = 32'h0;
    c = 1'h0;
    cs = VAT_CAUSE_NONE;
    h = -1;
    for (int i = 0; i < 16; i++) begin
      if (m_vpn[i] == va[31:12] && (m_g[i] || m_pid[i] == cur_pid)) h = i;
    end
    if (us && va[31]) cs = VAT_CAUSE_SUPER;
    else if (va[31:30] == 2'b11) begin
      pa = {3'h0, va[28:0]};
      c = !va[29];
    end else if (h < 0) cs = eh ? VAT_CAUSE_DOUBLE : VAT_CAUSE_FAST;
    else if ((k == VAT_KIND_FETCH && !m_dat[h][23]) || (k == VAT_KIND_LOAD && !m_dat[h][21]) ||
             (k == VAT_KIND_STORE && !m_dat[h][22])) cs = VAT_CAUSE_PERM;
    else begin
      pa = {m_dat[h][19:0], va[11:0]};
      c = m_dat[h][20];
    end
    if (k == VAT_KIND_FETCH || io) c = 1'h0;
    if (cs != VAT_CAUSE_NONE) begin
      pa = 32'h0;
      c = 1'h0;
      eh = 1'h1;
      pend = 1'h1;
      fcause = cs;
      faddr = va;
    end
    return {1'h1, pa, c, cs != VAT_CAUSE_NONE, cs};
  endfunction
  initial begin
    logic [31:0] rd, va;
    logic        err, io, us;
    logic [1:0]  k;
    logic [37:0] res, ex;
    int          sel, ei;
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    {cur_pid, eh, pend, fcause, faddr} = '0;
    for (int i = 0; i < 16; i++) begin
      m_vpn[i] = VAT_TAG_RST_BASE + 20'(i);
      m_pid[i] = '0;
      m_g[i] = 1'h0;
      m_dat[i] = 24'h0;
    end
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    ei = $urandom(54251);
    // reset values, unmapped word and unaligned write are refused
    apb(1'h1, 32'h2, 32'hffffffff, rd, err);
    chk({err, rd}, {1'h1, 32'h0});
    for (int a = 0; a < 8; a++) begin
      apb(1'h0, 32'(a * 4), 32'h0, rd, err);
      chk({err, rd}, {a == 7, 32'h0});
    end
    // entries alternate between user and mapped kernel pages, all distinct
    for (int i = 0; i < 8; i++) begin
      m_vpn[i] = {i[0], 1'h0, 14'($urandom), 4'(i)};
      m_pid[i] = PW'($urandom % 4);
      m_g[i] = ($urandom % 4) == 0;
      m_dat[i] = 24'($urandom);
      apb(1'h1, 32'(VAT_OFS_IDX), 32'(i), rd, err);
      apb(1'h1, 32'(VAT_OFS_TAG), {11'h0, m_g[i], m_vpn[i]}, rd, err);
      apb(1'h1, 32'(VAT_OFS_TPID), 32'(m_pid[i]), rd, err);
      apb(1'h1, 32'(VAT_OFS_DATA), {8'h0, m_dat[i]}, rd, err);
    end
    for (int t = 0; t < 400; t++) begin
      ei = $urandom % 8;
      sel = $urandom % 4;
      va = $urandom;
      if (sel < 2) va = {m_vpn[ei], va[11:0]};
      else if (sel == 2) va = {2'b11, va[29:0]};
      k = 2'($urandom);
      io = ($urandom % 4) == 0;
      us = 1'($urandom);
      ex = predict(va, k, io, us);
      vat_pipe_model_inst.issue(va, k, io, us, res);
      chk(res, ex);
      if (t % 16 == 15) begin
        check_regs();
        cur_pid = PW'($urandom % 4);
        eh = 1'($urandom);
        pend = 1'h0;
        apb(1'h1, 32'(VAT_OFS_CTRL), 32'({eh, 16'h0}) | 32'(cur_pid), rd, err);
        apb(1'h1, 32'(VAT_OFS_FCAUS), 32'h100, rd, err);
      end
    end
    check_regs();
    summarize();
  end
endmodule
`default_nettype wire
